/* File: rtl/pwp_pkg.sv */
// Shared constants and types for the page walk protection unit.
package pwp_pkg;

	// Entry bit positions, common to both table levels.
	localparam int ENT_P_BIT   = 0;     // Present.
	localparam int ENT_W_BIT   = 1;     // Writable.
	localparam int ENT_U_BIT   = 2;     // User level page.
	localparam int ENT_CD_BIT  = 4;     // No-cache flag.
	localparam int ENT_A_BIT   = 5;     // Accessed.
	localparam int ENT_D_BIT   = 6;     // Dirty.
	localparam int ENT_PS_BIT  = 7;     // Large (4-Mbyte) page in the top level entry.

	// Virtual and frame field layout.
	localparam int DIR_HI      = 31;    // Top index field.
	localparam int DIR_LO      = 22;
	localparam int PAGE_HI     = 21;    // Page index field.
	localparam int PAGE_LO     = 12;
	localparam int FRAME1_LO   = 22;    // 10-bit frame of a large page.
	localparam int FRAME2_LO   = 12;    // 20-bit frame of a small page or a table.
	localparam logic [1:0] IDX_PAD = 2'h0; // Two zero bits closing an entry address.

	// Register byte offsets on the APB.
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_BASE     = 12'h004;
	localparam logic [11:0] REG_STATUS   = 12'h008;
	localparam logic [11:0] REG_FAULT_VA = 12'h00C;

	// Control register bits.
	localparam int CTRL_TE_BIT = 0;     // translation_enable.
	localparam int CTRL_WG_BIT = 1;     // Supervisor write guard.
	localparam int CTRL_BO_BIT = 2;     // byte_order_select, never applied to table entries.
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Status register bits.
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_LOCK_BIT  = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam int ST_KIND_BIT  = 3;

	// Walker states.
	typedef enum logic [2:0] {
		PWP_IDLE,
		PWP_TOP_RD,
		PWP_TOP_LRD,
		PWP_TOP_WR,
		PWP_SEC_RD,
		PWP_SEC_LRD,
		PWP_SEC_WR
	} pwp_state_e;

endpackage

/* File: rtl/pwp_entry_check.sv */
// Protection check of one fetched table entry against the access in hand.
`timescale 1ns/1ps
module pwp_entry_check
(
	input  wire logic [31:0] entry_in,        // Entry as fetched, little-endian.
	input  wire logic        is_write_in,     // Access is a write.
	input  wire logic        user_in,         // Processor runs at user level.
	input  wire logic        guard_in,        // Supervisor write guard.
	input  wire logic        locked_seq_in,   // Miss arose inside a locked sequence.
	output logic             fault_out        // Entry refuses the access.
);

	// Each level is checked on its own, so a small page faults on whichever level is stricter.
	always_comb
	begin
		fault_out = 1'b0;
		if (!entry_in[pwp_pkg::ENT_P_BIT])
		begin
			// Nothing else of a non-present entry is meaningful.
			fault_out = 1'b1; // R07
		end
		else
		begin
			if (is_write_in && !entry_in[pwp_pkg::ENT_W_BIT] && (user_in || guard_in))
				fault_out = 1'b1; // R08
			if (!entry_in[pwp_pkg::ENT_U_BIT] && user_in)
				fault_out = 1'b1; // R09
			// A nested lock for the accessed update is refused with a fault instead.
			if (!entry_in[pwp_pkg::ENT_A_BIT] && locked_seq_in)
				fault_out = 1'b1; // R10
		end
	end

endmodule

/* File: rtl/pwp_walker.sv */
// Two-level page walker with protection checks, APB control and a memory master port.
//
// Notes on behaviour
// [R01] No-cache flag set forbids caching the page.
// [R02] Large page uses top flag, small uses second.
// [R03] Set accessed flag before use, both levels.
// [R04] Hold bus lock across accessed read-modify-write.
// [R05] Small page protection is the stricter level.
// [R06] Walk starts at base, top index, zeros.
// [R07] Top entry not present gives access fault.
// [R08] Write to read-only page faults under guard.
// [R09] Supervisor page at user level faults.
// [R10] Accessed clear inside locked sequence faults.
// [R11] Large page write with dirty clear faults.
// [R12] Accessed clear: lock, re-read, recheck, write back.
// [R13] Large page address is frame then offset.
// [R14] Small page: lock if needed, fetch second entry.
// [R15] Second entry gets the same checks.
// [R16] Small page write with second dirty clear faults.
// [R17] Both accessed already set: skip locked updates.
// [R18] Otherwise lock, refetch, set accessed, write back.
// [R19] Small page address is frame then offset.
// [R20] Entry reads bypass the data cache.
// [R21] Entries are always read little-endian.
// [R22] Software presets accessed for trap handler pages.
// [R23] Any fault stops the walk, no address.
`timescale 1ns/1ps
module pwp_walker
(
	input  wire logic        ref_clk_in,        // Core clock.
	input  wire logic        reset_n_in,        // Synchronous reset, active low.
	input  wire logic        ce_in,             // Clock enable, freezes all state when low.
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [31:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Translation request from the core.
	input  wire logic        req_valid_in,      // One-cycle request, taken while busy is low.
	input  wire logic [31:0] req_vaddr_in,      // Virtual address.
	input  wire logic        req_write_in,      // Write access.
	input  wire logic        req_instr_in,      // Instruction fetch.
	input  wire logic        req_user_in,       // Processor state word shows user level.
	input  wire logic        req_locked_in,     // Miss arose inside a locked sequence.
	output logic             busy_out,          // Walk in progress.
	output logic             done_out,          // One-cycle answer.
	output logic      [31:0] paddr_out,         // Physical address, zero on a fault.
	output logic             no_cache_out,      // Page may not be cached.
	output logic             fault_out,         // Access fault with this answer.
	output logic             fault_instr_out,   // Fault is an instruction-access fault.
	output logic      [31:0] fault_vaddr_out,   // Virtual address that faulted.
	// Memory master for table entries.
	output logic             mem_req_out,       // Held until acknowledged.
	output logic             mem_we_out,        // Write of an entry.
	output logic      [31:0] mem_addr_out,
	output logic      [31:0] mem_wdata_out,
	output logic             mem_uncached_out,  // Bypass the data cache.
	output logic             mem_lock_out,      // Bus lock.
	input  wire logic [31:0] mem_rdata_in,      // Entry, byte 0 in bits 7:0.
	input  wire logic        mem_ack_in         // Transfer completes at this edge.
);

	// Walker state.
	pwp_pkg::pwp_state_e state_r, state_nxt;
	logic        lock_r, lock_nxt;            // Bus lock held by the walker.
	logic        mreq_r, mreq_nxt;
	logic        mwe_r, mwe_nxt;
	logic [31:0] maddr_r, maddr_nxt;
	logic [31:0] mwdata_r, mwdata_nxt;
	logic [31:0] va_r, va_nxt;                // Latched access.
	logic        wr_r, wr_nxt;
	logic        instr_r, instr_nxt;
	logic        user_r, user_nxt;
	logic        lseq_r, lseq_nxt;
	logic [31:0] pde_r, pde_nxt;              // Top level entry as last read.
	logic        pde_a0_r, pde_a0_nxt;        // Top accessed flag was clear at walk start.
	logic        done_r, done_nxt;
	logic        busy_r, busy_nxt;            // Walk in progress, registered so the output is a flop.
	logic        fault_r, fault_nxt;
	logic        fkind_r, fkind_nxt;
	logic [31:0] paddr_r, paddr_nxt;
	logic        nc_r, nc_nxt;
	logic [31:0] fva_r, fva_nxt;

	// Register file.
	logic [2:0]  ctrl_r, ctrl_nxt;
	logic [19:0] base_r, base_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;

	// Entry check wiring.
	logic [31:0] entry;                       // Fetched entry, taken as little-endian.
	logic        chk_locked;                  // Locked-sequence check applies to this read.
	logic        chk_fault;
	logic        mem_done;                    // Memory transfer completes this edge.

	// Entries are used byte for byte; the data byte order setting never touches them.
	assign entry      = mem_rdata_in; // R21
	assign chk_locked = lseq_r && (state_r == pwp_pkg::PWP_TOP_RD || state_r == pwp_pkg::PWP_SEC_RD);
	assign mem_done   = mreq_r && mem_ack_in;

	pwp_entry_check u_check
	(
		.entry_in      (entry),
		.is_write_in   (wr_r),
		.user_in       (user_r),
		.guard_in      (ctrl_r[pwp_pkg::CTRL_WG_BIT]),
		.locked_seq_in (chk_locked),
		.fault_out     (chk_fault)
	);

	// Walk sequencing: every entry access is one held memory request.
	always_comb
	begin
		state_nxt  = state_r;
		lock_nxt   = lock_r;
		mreq_nxt   = mreq_r;
		mwe_nxt    = mwe_r;
		maddr_nxt  = maddr_r;
		mwdata_nxt = mwdata_r;
		va_nxt     = va_r;
		wr_nxt     = wr_r;
		instr_nxt  = instr_r;
		user_nxt   = user_r;
		lseq_nxt   = lseq_r;
		pde_nxt    = pde_r;
		pde_a0_nxt = pde_a0_r;
		done_nxt   = 1'b0;
		fault_nxt  = fault_r;
		fkind_nxt  = fkind_r;
		paddr_nxt  = paddr_r;
		nc_nxt     = nc_r;
		fva_nxt    = fva_r;
		if (mem_done)
			mreq_nxt = 1'b0;
		unique case (state_r)
			pwp_pkg::PWP_IDLE:
			begin
				if (req_valid_in)
				begin
					va_nxt    = req_vaddr_in;
					wr_nxt    = req_write_in;
					instr_nxt = req_instr_in;
					user_nxt  = req_user_in;
					lseq_nxt  = req_locked_in;
					if (ctrl_r[pwp_pkg::CTRL_TE_BIT])
					begin
						// First read: base, top index and two zero bits.
						maddr_nxt = {base_r, req_vaddr_in[pwp_pkg::DIR_HI:pwp_pkg::DIR_LO], pwp_pkg::IDX_PAD}; // R06
						mwe_nxt   = 1'b0;
						mreq_nxt  = 1'b1;
						state_nxt = pwp_pkg::PWP_TOP_RD;
					end
					else
					begin
						// Translation off: identity answer, cacheable.
						done_nxt  = 1'b1;
						fault_nxt = 1'b0;
						paddr_nxt = req_vaddr_in;
						nc_nxt    = 1'b0;
					end
				end
			end
			pwp_pkg::PWP_TOP_RD:
			begin
				if (mem_done)
				begin
					pde_nxt    = entry;
					pde_a0_nxt = !entry[pwp_pkg::ENT_A_BIT];
					if (chk_fault || (entry[pwp_pkg::ENT_P_BIT] && entry[pwp_pkg::ENT_PS_BIT]
						&& wr_r && !entry[pwp_pkg::ENT_D_BIT])) // R07 R08 R09 R10 R11
					begin
						state_nxt = pwp_pkg::PWP_IDLE;
						done_nxt  = 1'b1;
						fault_nxt = 1'b1; // R23
						fkind_nxt = instr_r;
						paddr_nxt = '0;
						fva_nxt   = va_r;
					end
					else if (!entry[pwp_pkg::ENT_A_BIT])
					begin
						// Locked re-read before setting the accessed flag.
						lock_nxt  = 1'b1; // R12 R04
						mreq_nxt  = 1'b1;
						state_nxt = pwp_pkg::PWP_TOP_LRD;
					end
					else if (entry[pwp_pkg::ENT_PS_BIT])
					begin
						state_nxt = pwp_pkg::PWP_IDLE;
						done_nxt  = 1'b1;
						fault_nxt = 1'b0;
						paddr_nxt = {entry[31:pwp_pkg::FRAME1_LO], va_r[pwp_pkg::FRAME1_LO-1:0]}; // R13
						nc_nxt    = entry[pwp_pkg::ENT_CD_BIT]; // R01 R02
					end
					else
					begin
						maddr_nxt = {entry[31:pwp_pkg::FRAME2_LO], va_r[pwp_pkg::PAGE_HI:pwp_pkg::PAGE_LO],
							pwp_pkg::IDX_PAD}; // R14
						mreq_nxt  = 1'b1;
						state_nxt = pwp_pkg::PWP_SEC_RD;
					end
				end
			end
			pwp_pkg::PWP_TOP_LRD, pwp_pkg::PWP_SEC_LRD:
			begin
				if (mem_done)
				begin
					if (chk_fault) // R12 R15
					begin
						// The walker's own lock is dropped; a core-held lock is not ours to touch.
						lock_nxt  = 1'b0;
						state_nxt = pwp_pkg::PWP_IDLE;
						done_nxt  = 1'b1;
						fault_nxt = 1'b1; // R23
						fkind_nxt = instr_r;
						paddr_nxt = '0;
						fva_nxt   = va_r;
					end
					else
					begin
						if (state_r == pwp_pkg::PWP_TOP_LRD)
							pde_nxt = entry;
						mwdata_nxt = entry | (32'h1 << pwp_pkg::ENT_A_BIT); // R03
						mwe_nxt    = 1'b1;
						mreq_nxt   = 1'b1;
						state_nxt  = (state_r == pwp_pkg::PWP_TOP_LRD) ? pwp_pkg::PWP_TOP_WR : pwp_pkg::PWP_SEC_WR;
					end
				end
			end
			pwp_pkg::PWP_TOP_WR:
			begin
				if (mem_done)
				begin
					mwe_nxt = 1'b0;
					if (pde_r[pwp_pkg::ENT_PS_BIT])
					begin
						lock_nxt  = 1'b0; // R12
						state_nxt = pwp_pkg::PWP_IDLE;
						done_nxt  = 1'b1;
						fault_nxt = 1'b0;
						paddr_nxt = {pde_r[31:pwp_pkg::FRAME1_LO], va_r[pwp_pkg::FRAME1_LO-1:0]}; // R13
						nc_nxt    = pde_r[pwp_pkg::ENT_CD_BIT]; // R01 R02
					end
					else
					begin
						// The accessed flag was clear at start, so the lock stays asserted for the table.
						lock_nxt  = 1'b1; // R14
						maddr_nxt = {pde_r[31:pwp_pkg::FRAME2_LO], va_r[pwp_pkg::PAGE_HI:pwp_pkg::PAGE_LO],
							pwp_pkg::IDX_PAD}; // R14
						mreq_nxt  = 1'b1;
						state_nxt = pwp_pkg::PWP_SEC_RD;
					end
				end
			end
			pwp_pkg::PWP_SEC_RD:
			begin
				if (mem_done)
				begin
					if (chk_fault || (wr_r && !entry[pwp_pkg::ENT_D_BIT])) // R15 R16 R05
					begin
						lock_nxt  = 1'b0;
						state_nxt = pwp_pkg::PWP_IDLE;
						done_nxt  = 1'b1;
						fault_nxt = 1'b1; // R23
						fkind_nxt = instr_r;
						paddr_nxt = '0;
						fva_nxt   = va_r;
					end
					else if (!pde_a0_r && entry[pwp_pkg::ENT_A_BIT])
					begin
						// Both accessed flags already set: no locked traffic at all.
						state_nxt = pwp_pkg::PWP_IDLE; // R17
						done_nxt  = 1'b1;
						fault_nxt = 1'b0;
						paddr_nxt = {entry[31:pwp_pkg::FRAME2_LO], va_r[pwp_pkg::FRAME2_LO-1:0]}; // R19
						nc_nxt    = entry[pwp_pkg::ENT_CD_BIT]; // R01 R02
					end
					else if (lock_r)
					begin
						// Already locked: this read is the locked one, write it back now.
						mwdata_nxt = entry | (32'h1 << pwp_pkg::ENT_A_BIT); // R18 R03
						mwe_nxt    = 1'b1;
						mreq_nxt   = 1'b1;
						state_nxt  = pwp_pkg::PWP_SEC_WR;
					end
					else
					begin
						lock_nxt  = 1'b1; // R18
						mreq_nxt  = 1'b1;
						state_nxt = pwp_pkg::PWP_SEC_LRD;
					end
				end
			end
			pwp_pkg::PWP_SEC_WR:
			begin
				if (mem_done)
				begin
					mwe_nxt   = 1'b0;
					lock_nxt  = 1'b0; // R18
					state_nxt = pwp_pkg::PWP_IDLE;
					done_nxt  = 1'b1;
					fault_nxt = 1'b0;
					paddr_nxt = {mwdata_r[31:pwp_pkg::FRAME2_LO], va_r[pwp_pkg::FRAME2_LO-1:0]}; // R19
					nc_nxt    = mwdata_r[pwp_pkg::ENT_CD_BIT]; // R01 R02
				end
			end
		endcase
		// Busy follows the state that the next edge will hold.
		busy_nxt = (state_nxt != pwp_pkg::PWP_IDLE);
	end

	// APB slave: one wait state, then a one-cycle ready.
	always_comb
	begin
		ctrl_nxt    = ctrl_r;
		base_nxt    = base_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		if (psel_in && penable_in && !pready_r)
		begin
			pready_nxt = 1'b1;
			prdata_nxt = '0;
			unique case (paddr_in[11:0])
				pwp_pkg::REG_CTRL:
				begin
					if (pwrite_in)
						ctrl_nxt = pwdata_in[2:0];
					prdata_nxt[2:0] = ctrl_r;
				end
				pwp_pkg::REG_BASE:
				begin
					if (pwrite_in)
						base_nxt = pwdata_in[31:pwp_pkg::FRAME2_LO];
					prdata_nxt[31:pwp_pkg::FRAME2_LO] = base_r;
				end
				pwp_pkg::REG_STATUS:
				begin
					prdata_nxt[pwp_pkg::ST_BUSY_BIT]  = (state_r != pwp_pkg::PWP_IDLE);
					prdata_nxt[pwp_pkg::ST_LOCK_BIT]  = lock_r;
					prdata_nxt[pwp_pkg::ST_FAULT_BIT] = fault_r;
					prdata_nxt[pwp_pkg::ST_KIND_BIT]  = fkind_r;
				end
				pwp_pkg::REG_FAULT_VA:
					prdata_nxt = fva_r;
				default:
					pslverr_nxt = 1'b1;
			endcase
			// A stray high address bit refuses the whole transfer, so no register is touched.
			if (paddr_in[31:12] != 20'h00000)
			begin
				pslverr_nxt = 1'b1;
				prdata_nxt  = '0;
				ctrl_nxt    = ctrl_r;
				base_nxt    = base_r;
			end
		end
	end

	// All state registers; held while the clock enable is low.
	always_ff @(posedge ref_clk_in)
	begin
		if (!reset_n_in)
		begin
			state_r   <= pwp_pkg::PWP_IDLE;
			lock_r    <= 1'b0;
			mreq_r    <= 1'b0;
			mwe_r     <= 1'b0;
			maddr_r   <= '0;
			mwdata_r  <= '0;
			va_r      <= '0;
			wr_r      <= 1'b0;
			instr_r   <= 1'b0;
			user_r    <= 1'b0;
			lseq_r    <= 1'b0;
			pde_r     <= '0;
			pde_a0_r  <= 1'b0;
			done_r    <= 1'b0;
			busy_r    <= 1'b0;
			fault_r   <= 1'b0;
			fkind_r   <= 1'b0;
			paddr_r   <= '0;
			nc_r      <= 1'b0;
			fva_r     <= '0;
			ctrl_r    <= pwp_pkg::CTRL_RESET;
			base_r    <= '0;
			prdata_r  <= '0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (ce_in)
		begin
			state_r   <= state_nxt;
			lock_r    <= lock_nxt;
			mreq_r    <= mreq_nxt;
			mwe_r     <= mwe_nxt;
			maddr_r   <= maddr_nxt;
			mwdata_r  <= mwdata_nxt;
			va_r      <= va_nxt;
			wr_r      <= wr_nxt;
			instr_r   <= instr_nxt;
			user_r    <= user_nxt;
			lseq_r    <= lseq_nxt;
			pde_r     <= pde_nxt;
			pde_a0_r  <= pde_a0_nxt;
			done_r    <= done_nxt;
			busy_r    <= busy_nxt;
			fault_r   <= fault_nxt;
			fkind_r   <= fkind_nxt;
			paddr_r   <= paddr_nxt;
			nc_r      <= nc_nxt;
			fva_r     <= fva_nxt;
			ctrl_r    <= ctrl_nxt;
			base_r    <= base_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Outputs come straight from flip-flops, except the uncached flag, which is tied high.
	assign prdata_out       = prdata_r;
	assign pready_out       = pready_r;
	assign pslverr_out      = pslverr_r;
	assign busy_out         = busy_r;
	assign done_out         = done_r;
	assign paddr_out        = paddr_r;
	assign no_cache_out     = nc_r;
	assign fault_out        = fault_r;
	assign fault_instr_out  = fkind_r;
	assign fault_vaddr_out  = fva_r;
	assign mem_req_out      = mreq_r;
	assign mem_we_out       = mwe_r;
	assign mem_addr_out     = maddr_r;
	assign mem_wdata_out    = mwdata_r;
	assign mem_uncached_out = 1'b1; // R20
	assign mem_lock_out     = lock_r;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	// Checks on the walk.
	AST_FIRST_READ: assert property (ce_in && state_r == pwp_pkg::PWP_IDLE && req_valid_in && ctrl_r[0] // R06
		|=> mem_req_out && mem_addr_out == {base_r, va_r[31:22], 2'h0}) else $error("first entry address wrong");
	AST_LOCKED_WRITE: assert property (mem_req_out && mem_we_out |-> mem_lock_out) // R04
		else $error("entry write without bus lock");
	AST_A_SET: assert property (mem_req_out && mem_we_out |-> mem_wdata_out[5]) // R03
		else $error("entry written back without accessed flag");
	AST_NOT_PRESENT: assert property (ce_in && mem_done && state_r == pwp_pkg::PWP_TOP_RD && !entry[0] // R07
		|=> done_out && fault_out && fault_instr_out == instr_r) else $error("absent top entry did not fault");
	AST_BIG_DIRTY: assert property (ce_in && mem_done && state_r == pwp_pkg::PWP_TOP_RD && wr_r // R11
		&& entry[pwp_pkg::ENT_PS_BIT] && !entry[pwp_pkg::ENT_D_BIT] |=> fault_out && done_out)
		else $error("large page dirty fault missed");
	AST_SMALL_DIRTY: assert property (ce_in && mem_done && state_r == pwp_pkg::PWP_SEC_RD && wr_r && !entry[6] // R16
		|=> fault_out && done_out && !mem_lock_out) else $error("small page dirty fault missed");
	AST_FAULT_NO_PA: assert property (done_out && fault_out |-> paddr_out == 32'h0 && fault_vaddr_out == va_r) // R23
		else $error("fault answer carries an address");
	AST_SKIP_LOCK: assert property (ce_in && mem_done && state_r == pwp_pkg::PWP_SEC_RD && !chk_fault && !wr_r // R17
		&& !pde_a0_r && entry[5] |=> done_out && paddr_out == {$past(entry[31:12]), va_r[11:0]} && !mem_lock_out)
		else $error("fully accessed walk took the locked path");
	AST_BIG_PA: assert property (done_out && !fault_out && state_r == pwp_pkg::PWP_IDLE && ctrl_r[0] && pde_r[7] // R13
		&& pde_r[0] |-> paddr_out == {pde_r[31:22], va_r[21:0]} && no_cache_out == pde_r[4])
		else $error("large page address or no-cache wrong");
	AST_LOCK_RELEASE: assert property (ce_in && mem_done && state_r == pwp_pkg::PWP_SEC_WR // R18
		|=> !mem_lock_out && done_out && !fault_out) else $error("lock held after write-back");
	COV_BIG: cover property (done_out && !fault_out && pde_r[7]);
	COV_SMALL_LOCKED: cover property (mem_req_out && mem_we_out && state_r == pwp_pkg::PWP_SEC_WR);
	COV_FAULT: cover property (done_out && fault_out && fault_instr_out);

endmodule

/* File: bench/pwp_mem_model.sv */
// Behavioural external memory that holds the top and second level tables.
`timescale 1ns/1ps
module pwp_mem_model
(
	input  wire logic        clk_in,    // Core clock.
	input  wire logic        req_in,    // Transfer request, held until answered.
	input  wire logic        we_in,     // Entry write.
	input  wire logic        lock_in,   // Bus lock.
	input  wire logic [31:0] addr_in,   // Entry address.
	input  wire logic [31:0] wdata_in,  // Entry to store.
	input  wire logic [1:0]  delay_in,  // Wait cycles before the answer.
	output logic             ack_out,   // Transfer completes at this edge.
	output logic      [31:0] rdata_out  // Entry, byte 0 in bits 7:0.
);
	logic [31:0] mem [logic [31:0]];   // Sparse table storage, loaded by the bench.
	logic [1:0]  wait_r;               // Cycles waited for the current transfer.
	int          lock_err;             // Entry writes seen without the bus lock.

	// Start quiet, with no answer pending.
	initial
	begin
		ack_out = 1'h0;
		wait_r = 2'h0;
		rdata_out = 32'h0;
		lock_err = 0;
	end

	// Answer after the chosen wait; with no request pending, or after an answer, the data line flips so stale data never passes.
	always @(posedge clk_in)
	begin
		if (ack_out || !req_in)
		begin
			ack_out <= 1'h0;
			wait_r <= 2'h0;
			rdata_out <= ~rdata_out;
		end
		else if (wait_r == delay_in)
		begin
			ack_out <= 1'h1;
			rdata_out <= mem[addr_in];
			if (we_in)
			begin
				mem[addr_in] = wdata_in;
				if (!lock_in)
					lock_err++;
			end
		end
		else
			wait_r <= wait_r + 2'h1;
	end
endmodule

/* File: bench/tb_pwp_walker.sv */
// Self-checking bench for the page walker against a behavioural table memory.
`timescale 1ns/1ps
module tb_pwp_walker;
	typedef struct {
		logic [31:0] ctl, top, sec, pa;
		logic [5:0]  f;                 // Write, user, instr, locked, fault, no-cache.
	} pwp_row_s;
	localparam logic [31:0] TA = 32'h00010004; // Top entry of the test address.
	localparam logic [31:0] SA = 32'h00020004; // Second entry of the test address.
	localparam logic [31:0] VA = 32'h00401234; // Top index 1, page index 1.
	logic        clk, rst_n, psel, pen, pwr, rv, rw, ri, ru, rl, e, ce;
	logic [31:0] paddr, pwd, rva, rd, prdata, pao, fva, maddr, mwd, mrd;
	logic        pready, pslverr, busy, done, ncf, flt, fin, mreq, mwe, munc, mlock, mack;
	logic [1:0]  dly;
	int          n_mismatch, comparisons;
	pwp_row_s    r;
	// Small pages use frame 55000, large pages frame C0000000.
	pwp_row_s rows [16] = '{
		'{32'h1, 32'h20027, 32'h55077, 32'h55234, 6'h11}, '{32'h1, 32'hC00000F7, 32'h0, 32'hC0001234, 6'h31},
		'{32'h1, 32'h0, 32'h0, 32'h0, 6'h0A}, '{32'h1, 32'h20025, 32'h0, 32'h0, 6'h32},
		'{32'h3, 32'h20025, 32'h0, 32'h0, 6'h22}, '{32'h1, 32'h20025, 32'h55067, 32'h55234, 6'h20},
		'{32'h1, 32'h20023, 32'h0, 32'h0, 6'h1A}, '{32'h1, 32'h20007, 32'h0, 32'h0, 6'h06},
		'{32'h1, 32'hC00000A7, 32'h0, 32'h0, 6'h22}, '{32'h1, 32'h20027, 32'h55027, 32'h0, 6'h32},
		'{32'h1, 32'h20017, 32'h55047, 32'h55234, 6'h30}, '{32'h1, 32'h20027, 32'h55063, 32'h0, 6'h12},
		'{32'h1, 32'h20027, 32'h55026, 32'h0, 6'h02}, '{32'h1, 32'h20027, 32'h55067, 32'h55234, 6'h04},
		'{32'h1, 32'h20027, 32'h55047, 32'h0, 6'h06}, '{32'h1, 32'hC0000097, 32'h0, 32'hC0001234, 6'h01}};

	pwp_walker dut (.ref_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .req_valid_in(rv), .req_vaddr_in(rva), .req_write_in(rw), .req_instr_in(ri),
		.req_user_in(ru), .req_locked_in(rl), .busy_out(busy), .done_out(done), .paddr_out(pao),
		.no_cache_out(ncf), .fault_out(flt), .fault_instr_out(fin), .fault_vaddr_out(fva), .mem_req_out(mreq),
		.mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_uncached_out(munc),
		.mem_lock_out(mlock), .mem_rdata_in(mrd), .mem_ack_in(mack));
	pwp_mem_model mem_i (.clk_in(clk), .req_in(mreq), .we_in(mwe), .lock_in(mlock), .addr_in(maddr),
		.wdata_in(mwd), .delay_in(dly), .ack_out(mack), .rdata_out(mrd));

	// Free-running core clock, 8 ns period.
	always #4 clk = ~clk;

	// Compare one value and count it; a mismatch is reported at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then end the run.
	task automatic stop_test;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pen <= 1'h0;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		e = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		// One idle edge keeps a following setup from re-driving psel in the same step.
		@(posedge clk);
	endtask

	// One-cycle translation request, then a wait for the answer with no limit of its own.
	task automatic walk(input logic [31:0] va, input logic w, input logic u, input logic i, input logic l);
		rv <= 1'h1;
		rva <= va;
		rw <= w;
		ru <= u;
		ri <= i;
		rl <= l;
		@(posedge clk);
		rv <= 1'h0;
		while (done !== 1'h1)
			@(posedge clk);
	endtask

	// A hang counts as a mismatch and ends the run the usual way.
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end

	// Main sequence: table of walks, then reset and the awkward cases.
	initial
	begin
		clk = 1'h0;
		rst_n = 1'h0;
		{psel, pen, pwr, rv, rw, ri, ru, rl} = '0;
		ce = 1'h1;
		{paddr, pwd, rva} = '0;
		dly = 2'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		apb(1'h1, 32'h4, 32'h00010000);
		for (int k = 0; k < 16; k++)
		begin
			r = rows[k];
			dly <= k[1:0];
			apb(1'h1, 32'h0, r.ctl);
			mem_i.mem[TA] = r.top;
			mem_i.mem[SA] = r.sec;
			walk(VA, r.f[5], r.f[4], r.f[3], r.f[2]);
			chk(busy, 1'h0);
			chk(flt, r.f[1]);
			if (r.f[1])
			begin
				chk(pao, 32'h0);
				chk(fin, r.f[3]);
				chk(fva, VA);
			end
			else
			begin
				chk(pao, r.pa);
				chk(ncf, r.f[0]);
				chk(mlock, 1'h0);
				chk(mem_i.mem[TA][5], 1'h1);
				if (!r.top[7])
					chk(mem_i.mem[SA][5], 1'h1);
			end
		end
		chk(munc, 1'h1);
		chk(mem_i.lock_err, 32'h0);
		apb(1'h0, 32'hC, 32'h0);
		chk(rd, VA);
		apb(1'h0, 32'h10, 32'h0);
		chk(e, 1'h1);
		chk(rd, 32'h0);
		// A write with a high address bit set is refused and leaves control as it was.
		apb(1'h1, 32'h1000, 32'h0);
		chk(e, 1'h1);
		apb(1'h0, 32'h0, 32'h0);
		chk(rd, 32'h1);
		chk(e, 1'h0);
		apb(1'h0, 32'h4, 32'h0);
		chk(rd, 32'h00010000);
		// Reset in mid-run must clear the control register again.
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		apb(1'h0, 32'h0, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 32'h8, 32'h0);
		chk(rd, 32'h0);
		// A request while the clock enable is low must not be taken.
		ce <= 1'h0;
		rv <= 1'h1;
		@(posedge clk);
		rv <= 1'h0;
		@(posedge clk);
		chk(done, 1'h0);
		chk(busy, 1'h0);
		ce <= 1'h1;
		walk(32'h12345678, 1'h1, 1'h1, 1'h0, 1'h0);
		chk(pao, 32'h12345678);
		chk(flt, 1'h0);
		stop_test();
	end
endmodule
